// >>> inc/radio_sleep_map.vh
// register offsets, fields, reset values and timing counts for sleep control
`ifndef RADIO_SLEEP_MAP_VH
`define RADIO_SLEEP_MAP_VH
`define OFS_TX_POWER 12'h000
`define OFS_CCA_THRESH 12'h004
`define OFS_SLEEP_MODE 12'h008
`define OFS_SLEEP_OPT 12'h00c
`define OFS_IDLE_LIMIT 12'h010
`define OFS_SLEEP_PERIOD 12'h014
`define OFS_UNASSOC_PERIOD 12'h018
`define OFS_CONTROL 12'h01c
`define OFS_STATUS 12'h020
`define TX_POWER_MAX 3'h4
`define TX_POWER_RST 3'h4
`define CCA_MIN 8'h24
`define CCA_MAX 8'h50
`define CCA_RST 8'h2c
`define SM_NONE 3'h0
`define SM_PIN_HIB 3'h1
`define SM_PIN_DOZE 3'h2
`define SM_RESERVED 3'h3
`define SM_CYC 3'h4
`define SM_CYC_PIN 3'h5
`define SM_LEGACY_COORD 3'h6
`define SM_RST 3'h0
`define SO_NO_POLL 0
`define SO_NO_SAMPLE 1
`define IDLE_RST 16'h1388
`define PERIOD_MAX 16'h68b0
`define SLEEP_PERIOD_RST 16'h0000
`define UNASSOC_RST 16'h03e8
`define CTL_COORD_EN 0
`define CTL_ASSOC_EN 1
`define CTL_SAMPLE_EN 2
`define TICK_NS 1000000
`define CLK_NS 4
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define TEN_MS_TICKS 10
`endif

// >>> hdl/radio_sleep_and_tx_gate_control.v
// sleep, idle and hold timing with transmit gating behind an apb slave
// Behaviour
// - transmit power select 0..4 picks one of five levels, resets to 4
// - a packet is suppressed when measured channel energy exceeds threshold
// - threshold is a -dBm magnitude held within 0x24..0x50, reset 0x2c
// - sleep mode 0 none, 1 hibernate, 2 doze, 3 reserved, 4/5 cyclic
// - mode 6 is legacy coordinator; otherwise coordinator enable bit
// - option bit 0 clear polls coordinator on each wake; set skips it
// - option bit 1 clear with sampling enabled samples once on wake
// - idle count restarts on traffic, sleeps at limit in ms, reset 0x1388
// - idle limit only acts in cyclic sleep modes 4 and 5
// - cyclic sleeper wakes at period end, checks data, else sleeps again
// - sleep period in 10 ms units, max 0x68b0, resets to zero
// - coordinator holds indirect message, drops after 2.5 sleep periods
// - coordinator with zero sleep period sends messages directly
// - unassociated sleeper sleeps the unassociated period, 1..0x68b0
`timescale 1ns/1ps
`include "radio_sleep_map.vh"
module radio_sleep_and_tx_gate_control #(
   parameter TICK_CYCLES = `TICK_CYCLES
) (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // activity and radio events
   input wire traffic,
   input wire associated,
   input wire data_pending,
   input wire tx_request,
   input wire [7:0] channel_energy,
   input wire indirect_msg_in,
   input wire indirect_delivered,
   // outputs to radio
   output reg tx_grant,
   output reg tx_blocked,
   output reg [2:0] tx_power_level,
   output reg asleep,
   output reg wake_poll,
   output reg wake_sample,
   output reg send_direct,
   output reg indirect_held,
   output reg indirect_discard,
   output reg [2:0] sleep_kind
);
   localparam ST_AWAKE = 2'h0;
   localparam ST_SLEEP = 2'h1;
   localparam ST_WAKE = 2'h2;

   reg [2:0] tx_power_reg;
   reg [7:0] cca_reg;
   reg [2:0] mode_reg;
   reg [1:0] opt_reg;
   reg [15:0] idle_limit_reg;
   reg [15:0] period_reg;
   reg [15:0] unassoc_reg;
   reg [2:0] ctl_reg;
   reg [31:0] tick_cnt_reg;
   reg tick_reg;
   reg [3:0] ten_cnt_reg;
   reg [15:0] idle_cnt_reg;
   reg [15:0] slp_cnt_reg;
   reg [17:0] hold_cnt_reg;
   reg [1:0] state_reg;

   // a write lands on the access edge, so it happens once per transfer
   wire wr = psel & penable & pwrite;
   wire [31:0] d = pwdata;
   // only aligned offsets 0x00..0x20 decode; others raise a slave error
   wire hit = (paddr[11:6] == 6'h00) & (paddr[1:0] == 2'h0) &
              (paddr[5:2] <= 4'h8);
   wire cyclic = (mode_reg == `SM_CYC) | (mode_reg == `SM_CYC_PIN);
   wire coord = ctl_reg[`CTL_COORD_EN] |
                (mode_reg == `SM_LEGACY_COORD);
   // the 10 ms step is the tick on which the tenth count completes
   wire ten_ms = tick_reg & (ten_cnt_reg == 4'h9);
   // an unassociated sleeper retries on its own, usually longer, period
   wire [15:0] cur_period = (ctl_reg[`CTL_ASSOC_EN] & ~associated) ?
                            unassoc_reg : period_reg;
   // hold limit 2.5 * period in 10 ms units is five 5 ms halves per unit;
   // 18 bits because five times the largest period overflows 17
   wire [17:0] hold_limit = {period_reg, 2'b00} + {2'b00, period_reg};

   function [15:0] clamp_period;
      input [15:0] v;
      input [15:0] lo;
      begin
         if (v > `PERIOD_MAX)
            clamp_period = `PERIOD_MAX;
         else if (v < lo)
            clamp_period = lo;
         else
            clamp_period = v;
      end
   endfunction

   // apb registers; out-of-range field values are clamped, except mode 7, which is refused; bits above a field are dropped, except for the threshold
   // clamping keeps every stored value legal, so writes to decoded offsets never error
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_power_reg <= `TX_POWER_RST;
         cca_reg <= `CCA_RST;
         mode_reg <= `SM_RST;
         opt_reg <= 2'h0;
         idle_limit_reg <= `IDLE_RST;
         period_reg <= `SLEEP_PERIOD_RST;
         unassoc_reg <= `UNASSOC_RST;
         ctl_reg <= 3'h0;
      end else if (wr & hit) begin
         case (paddr)
            `OFS_TX_POWER: begin
               if (d[2:0] > `TX_POWER_MAX)
                  tx_power_reg <= `TX_POWER_MAX;
               else
                  tx_power_reg <= d[2:0];
            end
            `OFS_CCA_THRESH: begin
               if (d[31:8] != 24'h0 || d[7:0] > `CCA_MAX)
                  cca_reg <= `CCA_MAX;
               else if (d[7:0] < `CCA_MIN)
                  cca_reg <= `CCA_MIN;
               else
                  cca_reg <= d[7:0];
            end
            `OFS_SLEEP_MODE: begin
               // mode 7 means nothing, so writing it keeps the old mode
               if (d[2:0] != 3'h7)
                  mode_reg <= d[2:0];
            end
            `OFS_SLEEP_OPT: opt_reg <= d[1:0];
            `OFS_IDLE_LIMIT: begin
               // a zero limit would sleep at once; one tick is the shortest
               if (d[15:0] == 16'h0)
                  idle_limit_reg <= 16'h0001;
               else
                  idle_limit_reg <= d[15:0];
            end
            `OFS_SLEEP_PERIOD:
               period_reg <= clamp_period(d[15:0], 16'h0000);
            `OFS_UNASSOC_PERIOD:
               unassoc_reg <= clamp_period(d[15:0], 16'h0001);
            `OFS_CONTROL: ctl_reg <= d[2:0];
            // status is read-only, so a write to it falls through here
            default: ;
         endcase
      end
   end

   // common millisecond tick
   // the tick is one clock wide; ten of them make one 10 ms step
   // the counter is wide enough for any tick length below 2^32 clocks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 32'h0;
         tick_reg <= 1'b0;
         ten_cnt_reg <= 4'h0;
      end else begin
         tick_reg <= (tick_cnt_reg == TICK_CYCLES - 1);
         if (tick_cnt_reg == TICK_CYCLES - 1)
            tick_cnt_reg <= 32'h0;
         else
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
         if (tick_reg)
            ten_cnt_reg <= (ten_cnt_reg == 4'h9) ? 4'h0 : ten_cnt_reg + 4'h1;
      end
   end

   // sleep sequencer: idle count, cyclic period, wake actions
   // traffic keeps the device awake and restarts the idle count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_AWAKE;
         idle_cnt_reg <= 16'h0;
         slp_cnt_reg <= 16'h0;
         asleep <= 1'b0;
         wake_poll <= 1'b0;
         wake_sample <= 1'b0;
      end else begin
         wake_poll <= 1'b0;
         wake_sample <= 1'b0;
         case (state_reg)
            ST_AWAKE: begin
               asleep <= 1'b0;
               slp_cnt_reg <= 16'h0;
               if (traffic | ~cyclic)
                  idle_cnt_reg <= 16'h0;
               else if (idle_cnt_reg >= idle_limit_reg) begin
                  state_reg <= ST_SLEEP;
                  asleep <= 1'b1;
                  idle_cnt_reg <= 16'h0;
               end else if (tick_reg)
                  idle_cnt_reg <= idle_cnt_reg + 16'h1;
            end
            ST_SLEEP: begin
               // a zero period wakes at the next 10 ms step
               // a new period takes effect at the next step, not at once
               if (~cyclic) begin
                  state_reg <= ST_AWAKE;
                  asleep <= 1'b0;
               end else if (ten_ms) begin
                  if (slp_cnt_reg + 16'h1 >= cur_period) begin
                     state_reg <= ST_WAKE;
                     asleep <= 1'b0;
                     slp_cnt_reg <= 16'h0;
                     wake_poll <= ~opt_reg[`SO_NO_POLL];
                     wake_sample <= ctl_reg[`CTL_SAMPLE_EN] &
                                    ~opt_reg[`SO_NO_SAMPLE];
                  end else
                     slp_cnt_reg <= slp_cnt_reg + 16'h1;
               end
            end
            ST_WAKE: begin
               // the radio answers the poll in this cycle window
               if (data_pending | traffic)
                  state_reg <= ST_AWAKE;
               else begin
                  state_reg <= ST_SLEEP;
                  asleep <= 1'b1;
               end
            end
            default: state_reg <= ST_AWAKE;
         endcase
      end
   end

   // indirect message hold on the coordinator
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt_reg <= 18'h0;
         indirect_held <= 1'b0;
         indirect_discard <= 1'b0;
         send_direct <= 1'b0;
      end else begin
         indirect_discard <= 1'b0;
         send_direct <= coord & (period_reg == 16'h0000);
         // one slot only: a newer message replaces the held one and restarts
         if (indirect_msg_in & coord & (period_reg != 16'h0000)) begin
            indirect_held <= 1'b1;
            hold_cnt_reg <= 18'h0;
         end else if (indirect_held) begin
            if (indirect_delivered | ~coord)
               indirect_held <= 1'b0;
            else if (hold_cnt_reg >= hold_limit) begin
               indirect_held <= 1'b0;
               indirect_discard <= 1'b1;
            // half steps fall at the fifth and tenth tick of each 10 ms
            end else if (tick_reg & (ten_cnt_reg == 4'h4 | ten_ms))
               hold_cnt_reg <= hold_cnt_reg + 18'h1;
         end
      end
   end

   // transmit gating and apb answer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_grant <= 1'b0;
         tx_blocked <= 1'b0;
         tx_power_level <= `TX_POWER_RST;
         sleep_kind <= `SM_RST;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // energy is a -dBm magnitude: smaller number means more energy
         // grant and block exclude each other and answer one cycle later
         tx_grant <= tx_request & (channel_energy >= cca_reg);
         tx_blocked <= tx_request & (channel_energy < cca_reg);
         tx_power_level <= tx_power_reg;
         sleep_kind <= (mode_reg == `SM_RESERVED) ? `SM_NONE : mode_reg;
         // zero wait states: ready rises in the access cycle after setup
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata <= 32'h0;
         // status shows the live sequencer state; nothing in it is latched
         if (psel & ~penable & ~pwrite & hit) begin
            case (paddr)
               `OFS_TX_POWER: prdata <= {29'h0, tx_power_reg};
               `OFS_CCA_THRESH: prdata <= {24'h0, cca_reg};
               `OFS_SLEEP_MODE: prdata <= {29'h0, mode_reg};
               `OFS_SLEEP_OPT: prdata <= {30'h0, opt_reg};
               `OFS_IDLE_LIMIT: prdata <= {16'h0, idle_limit_reg};
               `OFS_SLEEP_PERIOD: prdata <= {16'h0, period_reg};
               `OFS_UNASSOC_PERIOD: prdata <= {16'h0, unassoc_reg};
               `OFS_CONTROL: prdata <= {29'h0, ctl_reg};
               `OFS_STATUS: prdata <= {26'h0, indirect_held, coord,
                                       asleep, state_reg, cyclic};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end
endmodule

// >>> dv/sleep_gate_props.sv
// assertions on the ports of the sleep and transmit gate block
`timescale 1ns/1ps
module sleep_gate_props (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [11:0] paddr,
   input wire pready,
   input wire pslverr,
   // radio side
   input wire tx_request,
   input wire tx_grant,
   input wire tx_blocked,
   input wire [2:0] tx_power_level,
   input wire asleep,
   input wire wake_poll,
   input wire indirect_discard,
   input wire [2:0] sleep_kind
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   a_zero_wait: assert property (s_setup ##1 s_access |-> pready)
      else $error("access phase without ready");
   a_bad_addr: assert property ((s_access and pready) |->
      pslverr == (paddr > 12'h020 || paddr[1:0] != 2'h0))
      else $error("slave error does not match address");
   a_tx_answer: assert property (
      tx_request |=> tx_grant ^ tx_blocked) else $error("no gate answer");
   a_tx_quiet: assert property (
      !tx_request |=> !tx_grant && !tx_blocked) else $error("stray grant");
   a_power_range: assert property (
      tx_power_level <= 3'h4) else $error("power level above four");
   a_wake_step: assert property (
      wake_poll |-> !asleep && $past(asleep)) else $error("poll not at wake");
   a_poll_pulse: assert property (
      $rose(wake_poll) |=> $fell(wake_poll)) else $error("poll too long");
   a_drop_pulse: assert property (
      indirect_discard |=> !indirect_discard) else $error("discard too long");
   a_kind_reserved: assert property (
      sleep_kind != 3'h3) else $error("reserved mode reported");
endmodule
bind radio_sleep_and_tx_gate_control sleep_gate_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .tx_request(tx_request), .tx_grant(tx_grant), .tx_blocked(tx_blocked),
   .tx_power_level(tx_power_level), .asleep(asleep),
   .wake_poll(wake_poll), .indirect_discard(indirect_discard),
   .sleep_kind(sleep_kind));

// >>> dv/host_apb_model.sv
// host model driving the apb register port
`timescale 1ns/1ps
module host_apb_model (
   // clock
   input wire pclk,
   // apb master side
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [11:0] paddr = 12'h000,
   output logic [31:0] pwdata = 32'h0000_0000,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   // request held until ready is seen; no wait count is assumed
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// >>> dv/radio_sleep_and_tx_gate_control_bench.sv
// self-checking bench for the sleep and transmit gate block
`timescale 1ns/1ps
`include "radio_sleep_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   miscompares++; $display("ERROR t=%0t mismatch", $time); end end
module radio_sleep_and_tx_gate_control_bench;
   logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic traffic = 0, associated = 1, data_pending = 0, tx_request = 0;
   logic indirect_msg_in = 0, indirect_delivered = 0, err;
   logic [7:0] channel_energy = 8'h00;
   logic tx_grant, tx_blocked, asleep, wake_poll, wake_sample, send_direct;
   logic indirect_held, indirect_discard;
   logic [2:0] tx_power_level, sleep_kind;
   int miscompares = 0, samples_checked = 0, cycles = 0, n, i;
   always #2 pclk = ~pclk;
   host_apb_model host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   // ten clocks per tick keeps the 10 ms steps short
   radio_sleep_and_tx_gate_control #(.TICK_CYCLES(10)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .traffic(traffic), .associated(associated),
      .data_pending(data_pending), .tx_request(tx_request),
      .channel_energy(channel_energy), .indirect_msg_in(indirect_msg_in),
      .indirect_delivered(indirect_delivered), .tx_grant(tx_grant),
      .tx_blocked(tx_blocked), .tx_power_level(tx_power_level),
      .asleep(asleep), .wake_poll(wake_poll), .wake_sample(wake_sample),
      .send_direct(send_direct), .indirect_held(indirect_held),
      .indirect_discard(indirect_discard), .sleep_kind(sleep_kind));
   task wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd, err);
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0, rd, err);
      `CHK(rd, e)
   endtask
   task wrchk(input logic [11:0] a, input logic [31:0] d, e);
      wr(a, d);
      rdchk(a, e);
   endtask
   task settle;
      repeat (3) @(posedge pclk);
      #1;
   endtask
   task wrap_up;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up;
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      `CHK(tx_power_level, 3'h4)
      rdchk(`OFS_TX_POWER, 32'h4);
      rdchk(`OFS_CCA_THRESH, 32'h2c);
      rdchk(`OFS_SLEEP_MODE, 32'h0);
      rdchk(`OFS_IDLE_LIMIT, 32'h1388);
      rdchk(`OFS_SLEEP_PERIOD, 32'h0);
      rdchk(`OFS_UNASSOC_PERIOD, 32'h3e8);
      rdchk(12'h024, 32'h0);
      `CHK(err, 1'b1)
      wrchk(`OFS_TX_POWER, 32'h7, 32'h4);
      wrchk(`OFS_TX_POWER, 32'h2, 32'h2);
      `CHK(tx_power_level, 3'h2)
      wrchk(`OFS_CCA_THRESH, 32'h10, 32'h24);
      wrchk(`OFS_CCA_THRESH, 32'h60, 32'h50);
      for (i = 0; i < 7; i++) begin
         wrchk(`OFS_SLEEP_MODE, i, i);
         `CHK(sleep_kind, (i == 3) ? 3'h0 : i[2:0])
      end
      wrchk(`OFS_SLEEP_MODE, 32'h7, 32'h6);
      wrchk(`OFS_IDLE_LIMIT, 32'h0, 32'h1);
      wrchk(`OFS_SLEEP_PERIOD, 32'h7000, 32'h68b0);
      wrchk(`OFS_UNASSOC_PERIOD, 32'h0, 32'h1);
      // energy one stronger, equal to and one weaker than the threshold
      wr(`OFS_CCA_THRESH, 32'h40);
      for (i = 0; i < 3; i++) begin
         channel_energy <= 8'h3f + i[7:0];
         tx_request <= 1'b1;
         @(posedge pclk);
         tx_request <= 1'b0;
         #1;
         `CHK(tx_grant, i > 0)
         `CHK(tx_blocked, i == 0)
         @(posedge pclk);
      end
      wr(`OFS_CONTROL, 32'h1);
      wr(`OFS_SLEEP_PERIOD, 32'h0);
      settle;
      `CHK(send_direct, 1'b1)
      wr(`OFS_SLEEP_PERIOD, 32'h1);
      indirect_msg_in <= 1'b1;
      @(posedge pclk);
      indirect_msg_in <= 1'b0;
      settle;
      `CHK(indirect_held, 1'b1)
      `CHK(send_direct, 1'b0)
      n = 0;
      while (indirect_discard !== 1'b1) begin
         @(posedge pclk);
         n++;
      end
      `CHK(n inside {[200:270]}, 1'b1)
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_SLEEP_MODE, 32'h0);
      wr(`OFS_IDLE_LIMIT, 32'h3);
      repeat (100) @(posedge pclk);
      `CHK(asleep, 1'b0)
      traffic <= 1'b1;
      wr(`OFS_SLEEP_MODE, 32'h4);
      traffic <= 1'b0;
      repeat (15) @(posedge pclk);
      `CHK(asleep, 1'b0)
      repeat (40) @(posedge pclk);
      `CHK(asleep, 1'b1)
      while (wake_poll !== 1'b1) @(posedge pclk);
      `CHK(wake_sample, 1'b0)
      settle;
      `CHK(asleep, 1'b1)
      // skip the poll, enable sampling, then wait for the next wake
      wrchk(`OFS_SLEEP_OPT, 32'h1, 32'h1);
      wr(`OFS_CONTROL, 32'h4);
      while (asleep === 1'b1) @(posedge pclk);
      `CHK(wake_poll, 1'b0)
      `CHK(wake_sample, 1'b1)
      // the unassociated period stands in while the link is down
      wr(`OFS_UNASSOC_PERIOD, 32'h3);
      wr(`OFS_CONTROL, 32'h2);
      associated <= 1'b0;
      while (asleep !== 1'b0) @(posedge pclk);
      while (asleep !== 1'b1) @(posedge pclk);
      data_pending <= 1'b1;
      n = 0;
      while (asleep === 1'b1) begin
         @(posedge pclk);
         n++;
      end
      `CHK(n inside {[295:305]}, 1'b1)
      settle;
      `CHK(asleep, 1'b0)
      rdchk(`OFS_STATUS, 32'h1);
      wrap_up;
   end
endmodule
